/* File: core/line_status_ctrl.sv */
// Line status and handshake control of a serial port with an Avalon-MM register slave.
//
// Overview of operation
// - FIFO error flag is 0 without FIFOs; set while any queued entry has an error.
// - FIFO error flag clears on a status read only when no errored entries remain.
// - Without FIFOs, transmitter empty means holding and shift registers empty; resets to 1.
// - With FIFOs, transmitter empty means transmit queue and shift register empty.
// - Without FIFOs, holding empty sets on transfer to shifter; may raise an interrupt.
// - With FIFOs, holding empty sets when the transmit queue empties; resets to 1.
// - Holding empty clears when the CPU writes a transmit byte.
// - Break flag sets when the line stays low for one whole character time.
// - Framing flag sets when a character lacks a valid stop bit.
// - Parity flag sets when a character carries a wrong parity bit.
// - Overrun sets when a new character arrives at a full queue (replacing the unread one, or dropped with FIFOs), not on fullness.
// - With FIFOs, break, framing and parity describe the head entry.
// - Status read clears break, framing, parity and overrun flags.
// - Data ready is 1 while any received character waits, else 0.
// - Loopback holds serial output at 1 and ignores serial input.
// - Loopback drives all modem outputs inactive.
// - Loopback feeds DTR to DSR, RTS to CTS, ring bit to RI, IRQ bit to DCD.
// - Apart from loopback substitutions, the port keeps operating normally.
// - Interrupt output is enabled only while the IRQ enable bit is 1.
// - Ring control bit only matters in loopback, standing in for ring input.
// - Request-to-send pin is the inverse of its control bit.
// - Data-terminal-ready pin is the inverse of its control bit.
// - FIFO mode is active exactly when the FIFO enable bit is 1.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module line_status_ctrl
  import lsr_mcr_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT,
  parameter int CHAR_BITS  = CHAR_BITS_DEFAULT,
  parameter int RX_DEPTH   = RX_DEPTH_DEFAULT,
  parameter int TX_DEPTH   = TX_DEPTH_DEFAULT
) (
  // Clock and reset.
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  // Avalon-MM slave.
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Receiver engine.
  output logic             RX_LINE,
  input  wire logic        RX_CHAR_VALID,
  input  wire rx_entry_t   RX_CHAR,
  // Transmitter engine.
  output logic [7:0]       TX_DATA,
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  input  wire logic        TX_SHIFT_BUSY,
  input  wire logic        TX_SERIAL,
  // Serial pins.
  output logic             SERIAL_OUT,
  input  wire logic        SERIAL_IN,
  // Modem pins.
  output logic             RTS_N,
  output logic             DTR_N,
  input  wire logic        CTS_N,
  input  wire logic        DSR_N,
  input  wire logic        RING_N,
  input  wire logic        CARRIER_N,
  output modem_t           MODEM_STATUS,
  // Interrupt.
  input  wire logic        IRQ_REQ,
  output logic             IRQ
);
  localparam int BREAK_CYCLES = BIT_CYCLES * CHAR_BITS;
  localparam int BW           = $clog2(BREAK_CYCLES + 1);
  localparam int RAW          = $clog2(RX_DEPTH);

  initial begin
    if (BIT_CYCLES < 1 || CHAR_BITS < 7 || CHAR_BITS > 12) begin
      $error("line_status_ctrl: BIT_CYCLES or CHAR_BITS out of range");
    end
  end

  // Register bus handshake: one wait cycle, effects at the releasing edge.
  bus_state_t bus_state;
  logic       bus_req;
  logic       bus_fire;
  logic       rd_fire;
  logic       wr_fire;
  logic [2:0] bus_idx;
  logic       lane0;

  function automatic logic hit(input logic [2:0] idx, input logic [2:0] want);
    hit = (idx == want);
  endfunction : hit

  assign bus_req         = AVS_READ || AVS_WRITE;
  assign bus_idx         = AVS_ADDRESS[4:2];
  assign lane0           = AVS_BYTEENABLE[0];
  assign AVS_WAITREQUEST = bus_req && (bus_state == BUS_IDLE);
  assign bus_fire        = bus_req && (bus_state == BUS_DONE);
  assign rd_fire         = bus_fire && AVS_READ;
  assign wr_fire         = bus_fire && AVS_WRITE && lane0;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: bus_state <= bus_req ? BUS_DONE : BUS_IDLE;
        BUS_DONE: bus_state <= BUS_IDLE;
        default:  bus_state <= BUS_IDLE;
      endcase
    end
  end

  // Software registers.
  logic [7:0] handshake_control;
  logic [3:0] interrupt_enable_reg;
  logic       fifo_mode;
  logic       rx_clear;
  logic       tx_clear;
  logic       loopback;

  assign loopback = handshake_control[HC_LOOPBACK];

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      handshake_control    <= HANDSHAKE_RESET;
      interrupt_enable_reg <= IRQ_EN_RESET;
      fifo_mode            <= FIFO_EN_RESET;
    end else if (wr_fire) begin
      if (hit(bus_idx, IDX_HANDSHAKE)) begin
        handshake_control <= {3'h0, AVS_WRITEDATA[4:0]};
      end
      if (hit(bus_idx, IDX_IRQ_EN)) begin
        interrupt_enable_reg <= AVS_WRITEDATA[3:0];
      end
      if (hit(bus_idx, IDX_FIFO_CTRL)) begin
        fifo_mode <= AVS_WRITEDATA[FC_ENABLE];
      end
    end
  end

  // Switching FIFO mode flushes both queues; each explicit reset bit flushes only its own queue.
  always_comb begin
    rx_clear = 1'b0;
    tx_clear = 1'b0;
    if (wr_fire && hit(bus_idx, IDX_FIFO_CTRL)) begin
      rx_clear = AVS_WRITEDATA[FC_RX_RESET] || (AVS_WRITEDATA[FC_ENABLE] != fifo_mode);
      tx_clear = AVS_WRITEDATA[FC_TX_RESET] || (AVS_WRITEDATA[FC_ENABLE] != fifo_mode);
    end
  end

  // Pins and loopback.
  logic   line_in;
  modem_t modem_in;

  assign line_in    = loopback ? TX_SERIAL : SERIAL_IN;
  assign RX_LINE    = line_in;
  assign SERIAL_OUT = loopback ? 1'b1 : TX_SERIAL;
  assign RTS_N      = loopback ? 1'b1 : ~handshake_control[HC_RTS];
  assign DTR_N      = loopback ? 1'b1 : ~handshake_control[HC_DTR];

  always_comb begin
    if (loopback) begin
      modem_in.dsr = handshake_control[HC_DTR];
      modem_in.cts = handshake_control[HC_RTS];
      modem_in.ri  = handshake_control[HC_LOOP_RI];
      modem_in.dcd = handshake_control[HC_IRQ_EN];
    end else begin
      modem_in.dsr = ~DSR_N;
      modem_in.cts = ~CTS_N;
      modem_in.ri  = ~RING_N;
      modem_in.dcd = ~CARRIER_N;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      MODEM_STATUS <= '0;
    end else begin
      MODEM_STATUS <= modem_in;
    end
  end

  // Break detection: one event per unbroken low stretch of a character time.
  logic [BW-1:0] low_count;
  logic          break_event;

  assign break_event = !line_in && (low_count == BW'(BREAK_CYCLES - 1));

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || line_in) begin
      low_count <= '0;
    end else if (low_count != BW'(BREAK_CYCLES)) begin
      low_count <= low_count + 1'b1;
    end
  end

  // Receive queue; a break enters as a zero character carrying its flag.
  rx_entry_t        rx_in;
  rx_entry_t        rx_head;
  logic             rx_push;
  logic             rx_pop;
  logic             rx_full;
  logic             rx_empty;
  logic [RAW:0]     rx_count;
  logic             rx_overwrite;
  logic             data_read;

  always_comb begin
    rx_in     = RX_CHAR_VALID ? RX_CHAR : '0;
    rx_in.brk = rx_in.brk || break_event;
  end

  assign rx_push      = RX_CHAR_VALID || break_event;
  assign data_read    = rd_fire && hit(bus_idx, IDX_DATA);
  // Single-buffered mode replaces the unread byte; FIFO mode drops the newcomer.
  assign rx_overwrite = rx_push && rx_full && !data_read;
  assign rx_pop       = data_read || (rx_overwrite && !fifo_mode);

  char_fifo #(
    .WIDTH ($bits(rx_entry_t)),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .clear     (rx_clear),
    .single    (!fifo_mode),
    .push      (rx_push),
    .push_data (rx_in),
    .pop       (rx_pop),
    .head      (rx_head),
    .count     (rx_count),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  // Count of queued entries that carry any error, for the aggregate flag.
  logic [RAW:0] err_count;
  logic         in_err;
  logic         head_err;
  logic         push_ok;
  logic         pop_ok;

  assign in_err   = rx_in.brk || rx_in.framing || rx_in.parity;
  assign head_err = rx_head.brk || rx_head.framing || rx_head.parity;
  assign push_ok  = rx_push && (!rx_full || rx_pop);
  assign pop_ok   = rx_pop && !rx_empty;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || rx_clear) begin
      err_count <= '0;
    end else begin
      err_count <= err_count + (RAW+1)'(push_ok && in_err) - (RAW+1)'(pop_ok && head_err);
    end
  end

  // A new head appears when data lands in an empty queue or a pop leaves some behind.
  logic head_new;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || rx_clear) begin
      head_new <= 1'b0;
    end else begin
      head_new <= (push_ok && rx_empty) || (pop_ok && rx_count > (RAW+1)'(1)) ||
                  (pop_ok && push_ok && rx_count == (RAW+1)'(1));
    end
  end

  // Transmit queue toward the shifter.
  logic         tx_write;
  logic         tx_pop;
  logic         tx_full;
  logic         tx_empty;
  logic [$clog2(TX_DEPTH):0] tx_count;

  assign tx_write = wr_fire && hit(bus_idx, IDX_DATA);
  assign TX_VALID = !tx_empty;
  assign tx_pop   = TX_VALID && TX_READY;

  char_fifo #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .clear     (tx_clear),
    .single    (!fifo_mode),
    .push      (tx_write && !tx_full),
    .push_data (AVS_WRITEDATA[7:0]),
    .pop       (tx_pop),
    .head      (TX_DATA),
    .count     (tx_count),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  // Line status flags. Hardware set wins over a read clear in the same cycle.
  logic [7:0] line_status;
  logic       stat_read;

  assign stat_read = rd_fire && hit(bus_idx, IDX_LINE_STAT);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      line_status <= LINE_STAT_RESET;
    end else begin
      line_status[LS_DATA_READY] <= !rx_empty;
      line_status[LS_TX_EMPTY]   <= tx_empty && !TX_SHIFT_BUSY && !tx_pop;
      if (stat_read) begin
        line_status[LS_OVERRUN] <= 1'b0;
        line_status[LS_PARITY]  <= 1'b0;
        line_status[LS_FRAMING] <= 1'b0;
        line_status[LS_BREAK]   <= 1'b0;
      end
      if (rx_overwrite) begin
        line_status[LS_OVERRUN] <= 1'b1;
      end
      if (head_new) begin
        line_status[LS_PARITY]  <= line_status[LS_PARITY]  && !stat_read || rx_head.parity;
        line_status[LS_FRAMING] <= line_status[LS_FRAMING] && !stat_read || rx_head.framing;
        line_status[LS_BREAK]   <= line_status[LS_BREAK]   && !stat_read || rx_head.brk;
      end
      // Aggregate error: cleared by a read only once the queue holds no errors.
      if (!fifo_mode) begin
        line_status[LS_FIFO_ERR] <= 1'b0;
      end else if (err_count != '0) begin
        line_status[LS_FIFO_ERR] <= 1'b1;
      end else if (stat_read) begin
        line_status[LS_FIFO_ERR] <= 1'b0;
      end
      // A write that races the last transfer keeps holding empty clear; without FIFOs that byte is dropped.
      if (tx_write) begin
        line_status[LS_HOLD_EMPTY] <= 1'b0;
      end else if (tx_pop && tx_count == (($clog2(TX_DEPTH))+1)'(1)) begin
        line_status[LS_HOLD_EMPTY] <= 1'b1;
      end else if (tx_clear) begin
        line_status[LS_HOLD_EMPTY] <= 1'b1;
      end
    end
  end

  // Interrupt gate: the holding-empty request joins external requests.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= handshake_control[HC_IRQ_EN] && (IRQ_REQ ||
             (interrupt_enable_reg[IE_HOLD_EMPTY] && line_status[LS_HOLD_EMPTY]));
    end
  end

  // Read data is captured in the wait cycle, so a status read returns pre-clear flags.
  logic [7:0] next_rdata;

  always_comb begin
    case (bus_idx)
      IDX_DATA:       next_rdata = rx_head.data;
      IDX_IRQ_EN:     next_rdata = {4'h0, interrupt_enable_reg};
      IDX_FIFO_CTRL:  next_rdata = {fifo_mode, fifo_mode, 6'h00};
      IDX_HANDSHAKE:  next_rdata = handshake_control;
      IDX_LINE_STAT:  next_rdata = line_status;
      IDX_MODEM_STAT: next_rdata = {MODEM_STATUS, 4'h0};
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && bus_state == BUS_IDLE) begin
      AVS_READDATA <= {24'h00_0000, next_rdata};
    end
  end

endmodule : line_status_ctrl
`default_nettype wire

/* File: pkg/lsr_mcr_pkg.sv */
// Shared constants and types for the serial port status and handshake block.
package lsr_mcr_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [2:0] IDX_DATA      = 3'h0;
  localparam logic [2:0] IDX_IRQ_EN    = 3'h1;
  localparam logic [2:0] IDX_FIFO_CTRL = 3'h2;
  localparam logic [2:0] IDX_HANDSHAKE = 3'h4;
  localparam logic [2:0] IDX_LINE_STAT = 3'h5;
  localparam logic [2:0] IDX_MODEM_STAT = 3'h6;

  // Line status bit positions.
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN    = 1;
  localparam int LS_PARITY     = 2;
  localparam int LS_FRAMING    = 3;
  localparam int LS_BREAK      = 4;
  localparam int LS_HOLD_EMPTY = 5;
  localparam int LS_TX_EMPTY   = 6;
  localparam int LS_FIFO_ERR   = 7;

  // Handshake control bit positions.
  localparam int HC_DTR      = 0;
  localparam int HC_RTS      = 1;
  localparam int HC_LOOP_RI  = 2;
  localparam int HC_IRQ_EN   = 3;
  localparam int HC_LOOPBACK = 4;

  // FIFO control and interrupt enable bit positions.
  localparam int FC_ENABLE   = 0;
  localparam int FC_RX_RESET = 1;
  localparam int FC_TX_RESET = 2;
  localparam int IE_HOLD_EMPTY = 1;

  // Modem status bit positions (current levels, active high).
  localparam int MS_CTS = 4;
  localparam int MS_DSR = 5;
  localparam int MS_RI  = 6;
  localparam int MS_DCD = 7;

  // Reset values.
  localparam logic [7:0] LINE_STAT_RESET = 8'h60;
  localparam logic [7:0] HANDSHAKE_RESET = 8'h00;
  localparam logic [3:0] IRQ_EN_RESET    = 4'h0;
  localparam logic       FIFO_EN_RESET   = 1'b0;

  // Timing defaults for the break detector, and default receive and transmit queue depths.
  localparam int BIT_CYCLES_DEFAULT = 868;
  localparam int CHAR_BITS_DEFAULT  = 11;
  localparam int RX_DEPTH_DEFAULT   = 16;
  localparam int TX_DEPTH_DEFAULT   = 16;

  typedef struct packed {
    logic       brk;
    logic       framing;
    logic       parity;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DONE = 2'b01
  } bus_state_t;

endpackage : lsr_mcr_pkg

/* File: core/char_fifo.sv */
// Small synchronous FIFO with a run-time capacity limit and head-of-queue output.
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Control.
  input  wire logic                     clear,
  input  wire logic                     single,
  // Fill side.
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         push_data,
  // Drain side.
  input  wire logic                     pop,
  output logic      [WIDTH-1:0]         head,
  // Level.
  output logic      [$clog2(DEPTH):0]   count,
  output logic                          full,
  output logic                          empty
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("char_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic             do_pop;
  logic             do_push;

  // In single mode the queue holds one entry, as a plain holding register.
  assign full    = single ? (count != '0) : (count == (AW+1)'(DEPTH));
  assign empty   = (count == '0);
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign head    = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

endmodule : char_fifo
`default_nettype wire

/* File: tb/lsr_mcr_monitor.sv */
// Concurrent checks on the ports of the serial port status and handshake block.
`timescale 1ns/1ps
`default_nettype none
module lsr_mcr_monitor
  import lsr_mcr_pkg::*;
(
  // Clock and reset.
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  // Register bus.
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic        AVS_WAITREQUEST,
  // Serial and modem pins.
  input wire logic        RX_LINE,
  input wire logic        TX_SERIAL,
  input wire logic        SERIAL_OUT,
  input wire logic        SERIAL_IN,
  input wire logic        RTS_N,
  input wire logic        DTR_N,
  input wire logic        CTS_N,
  input wire logic        DSR_N,
  input wire logic        RING_N,
  input wire logic        CARRIER_N,
  input wire modem_t      MODEM_STATUS,
  // Interrupt.
  input wire logic        IRQ_REQ,
  input wire logic        IRQ
);
  logic [4:0] hc;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // Shadow of the handshake register, so pin checks need no view inside the block.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      hc <= 5'h00;
    end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == IDX_HANDSHAKE
                 && AVS_BYTEENABLE[0]) begin
      hc <= AVS_WRITEDATA[4:0];
    end
  end
  a_rts_pin_level: assert property (RTS_N == (hc[HC_LOOPBACK] | ~hc[HC_RTS]))
    else $error("request to send pin wrong");
  a_dtr_pin_level: assert property (DTR_N == (hc[HC_LOOPBACK] | ~hc[HC_DTR]))
    else $error("terminal ready pin wrong");
  a_serial_out_forced: assert property (SERIAL_OUT == (hc[HC_LOOPBACK] | TX_SERIAL))
    else $error("serial output wrong");
  a_rx_line_source: assert property (RX_LINE == (hc[HC_LOOPBACK] ? TX_SERIAL : SERIAL_IN))
    else $error("receive line source wrong");
  a_modem_loop_map: assert property ($past(hc[HC_LOOPBACK]) && !$past(SYS_RST) |->
    MODEM_STATUS == {$past(hc[HC_IRQ_EN]), $past(hc[HC_LOOP_RI]), $past(hc[HC_DTR]),
                     $past(hc[HC_RTS])})
    else $error("loopback modem status wrong");
  a_modem_pins_follow: assert property (!$past(hc[HC_LOOPBACK]) && !$past(SYS_RST) |->
    MODEM_STATUS == {~$past(CARRIER_N), ~$past(RING_N), ~$past(DSR_N), ~$past(CTS_N)})
    else $error("modem status does not follow pins");
  a_irq_gated_off: assert property (!$past(hc[HC_IRQ_EN]) |-> !IRQ)
    else $error("interrupt while output disabled");
  a_irq_passes_req: assert property (IRQ_REQ && hc[HC_IRQ_EN] |=> IRQ)
    else $error("enabled interrupt request lost");
  a_wait_first_cycle: assert property
    ((AVS_READ || AVS_WRITE) && !$past(AVS_READ) && !$past(AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("no wait cycle on new request");
  a_wait_one_cycle: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("wait longer than one cycle");
endmodule : lsr_mcr_monitor
`default_nettype wire

/* File: tb/tx_peer_model.sv */
// Behavioural transmit shifter that takes characters from the block and drives the line.
`timescale 1ns/1ps
`default_nettype none
module tx_peer_model #(
  parameter int BIT_TIME = 2
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Character hand-off.
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // Line side.
  input  wire logic       stall,
  output logic            busy,
  output logic            serial
);
  logic [9:0] frame;
  logic [3:0] bits;
  int         tick;
  // A stalled shifter refuses characters, so the holding stage of the block stays full.
  assign busy     = bits != 4'h0;
  assign tx_ready = !busy && !stall;
  // The line idles at mark between frames.
  assign serial   = busy ? frame[0] : 1'b1;
  always_ff @(posedge clk) begin
    if (rst) begin
      bits  <= 4'h0;
      tick  <= 0;
      frame <= '1;
    end else if (tx_valid && tx_ready) begin
      frame <= {1'b1, tx_data, 1'b0};
      bits  <= 4'ha;
      tick  <= 0;
    end else if (busy && tick == BIT_TIME - 1) begin
      frame <= {1'b1, frame[9:1]};
      bits  <= bits - 4'h1;
      tick  <= 0;
    end else if (busy) begin
      tick <= tick + 1;
    end
  end
endmodule : tx_peer_model
`default_nettype wire

/* File: tb/test_uart_line_status_modem_control.sv */
// Self-checking bench for the serial port status and handshake block.
`timescale 1ns/1ps
`default_nettype none
module test_uart_line_status_modem_control
  import lsr_mcr_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  address = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq, rx_line, tx_valid, tx_ready, tx_busy, tx_serial;
  logic        rx_valid = 1'b0;
  rx_entry_t   rx_char = '0;
  logic [7:0]  tx_data;
  logic        stall = 1'b1;
  logic        serial_in = 1'b1;
  logic        serial_out, rts_n, dtr_n, irq;
  logic [3:0]  modem_in_n = 4'hf;
  modem_t      modem_status;
  logic        irq_req = 1'b0;
  logic [7:0]  exp_q[$];
  logic [7:0]  tx_q[$];
  int          n_mismatch = 0;
  int          tests_run = 0;
  logic [7:0]  v;
  always #5 clk = ~clk;
  line_status_ctrl #(.BIT_CYCLES(4), .CHAR_BITS(8)) u_line_status_ctrl (
    .SYS_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(address), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_BYTEENABLE(4'hf), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .RX_LINE(rx_line), .RX_CHAR_VALID(rx_valid), .RX_CHAR(rx_char),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_SHIFT_BUSY(tx_busy),
    .TX_SERIAL(tx_serial), .SERIAL_OUT(serial_out), .SERIAL_IN(serial_in), .RTS_N(rts_n),
    .DTR_N(dtr_n), .CTS_N(modem_in_n[0]), .DSR_N(modem_in_n[1]), .RING_N(modem_in_n[2]),
    .CARRIER_N(modem_in_n[3]), .MODEM_STATUS(modem_status), .IRQ_REQ(irq_req), .IRQ(irq));
  tx_peer_model u_tx_peer_model (.clk(clk), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .stall(stall), .busy(tx_busy), .serial(tx_serial));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // One bus cycle; a read leaves its expected byte for the watcher below.
  task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d,
                     input logic [7:0] e);
    @(posedge clk);
    address <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {24'h0, d};
    if (!w) exp_q.push_back(e);
    // The request stands until waitrequest is seen low at a rising edge.
    @(posedge clk);
    while (waitreq !== 1'b0) begin
      @(posedge clk);
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [2:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 8'h00);
  endtask : wreg
  task automatic rreg(input logic [2:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, e);
  endtask : rreg
  task automatic rx_send(input logic b, input logic f, input logic p, input logic [7:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= '{brk: b, framing: f, parity: p, data: d};
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : rx_send
  // Lets the shifter run and waits, bounded, until nothing is queued or shifting.
  task automatic tx_drain;
    int n;
    n = 0;
    @(posedge clk);
    stall <= 1'b0;
    @(posedge clk);
    while ((tx_valid | tx_busy) !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    stall <= 1'b1;
  endtask : tx_drain
  always @(posedge clk) begin
    if (rd && waitreq === 1'b0) check(rdata, {24'h0, exp_q.pop_front()});
    if (tx_valid && tx_ready) check(tx_data, {24'h0, tx_q.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h5e01));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rreg(IDX_LINE_STAT, LINE_STAT_RESET);
    rreg(IDX_HANDSHAKE, HANDSHAKE_RESET);
    wreg(3'h7, 8'hff);
    rreg(3'h7, 8'h00);
    v = 8'($urandom) & 8'h0f;
    modem_in_n <= 4'($urandom);
    wreg(IDX_HANDSHAKE, v);
    rreg(IDX_HANDSHAKE, v);
    @(negedge clk);
    check({rts_n, dtr_n}, {~v[HC_RTS], ~v[HC_DTR]});
    check(modem_status, 4'(~modem_in_n));
    @(posedge clk);
    v = (8'($urandom) & 8'h0f) | 8'h10;
    serial_in <= 1'b0;
    wreg(IDX_HANDSHAKE, v);
    rreg(IDX_MODEM_STAT, {v[3], v[2], v[0], v[1], 4'h0});
    @(negedge clk);
    check({serial_out, rts_n, dtr_n, rx_line}, {3'b111, tx_serial});
    wreg(IDX_HANDSHAKE, 8'h00);
    serial_in <= 1'b1;
    v = 8'($urandom);
    rx_send(1'b0, 1'b0, 1'b1, v);
    rreg(IDX_LINE_STAT, 8'h65);
    rreg(IDX_DATA, v);
    rreg(IDX_LINE_STAT, 8'h60);
    rx_send(1'b1, 1'b1, 1'b0, 8'h00);
    rx_send(1'b0, 1'b0, 1'b0, v ^ 8'h5a);
    rreg(IDX_LINE_STAT, 8'h7b);
    rreg(IDX_DATA, v ^ 8'h5a);
    rreg(IDX_LINE_STAT, 8'h60);
    serial_in <= 1'b0;
    repeat (40) @(posedge clk);
    serial_in <= 1'b1;
    rreg(IDX_LINE_STAT, 8'h71);
    rreg(IDX_DATA, 8'h00);
    wreg(IDX_IRQ_EN, 8'h02);
    wreg(IDX_HANDSHAKE, 8'h08);
    v = 8'($urandom);
    tx_q.push_back(v);
    wreg(IDX_DATA, v);
    rreg(IDX_LINE_STAT, 8'h00);
    @(negedge clk);
    check(irq, 1'b0);
    tx_drain();
    repeat (2) @(negedge clk);
    check(irq, 1'b1);
    rreg(IDX_LINE_STAT, 8'h60);
    irq_req <= 1'b1;
    wreg(IDX_HANDSHAKE, 8'h00);
    repeat (2) @(negedge clk);
    check(irq, 1'b0);
    @(posedge clk);
    irq_req <= 1'b0;
    wreg(IDX_IRQ_EN, 8'h00);
    wreg(IDX_FIFO_CTRL, 8'h01);
    rreg(IDX_FIFO_CTRL, 8'hc0);
    rx_send(1'b0, 1'b0, 1'b1, v);
    rx_send(1'b0, 1'b0, 1'b0, ~v);
    rreg(IDX_LINE_STAT, 8'he5);
    rreg(IDX_DATA, v);
    rreg(IDX_LINE_STAT, 8'he1);
    rreg(IDX_LINE_STAT, 8'h61);
    rreg(IDX_DATA, ~v);
    repeat (2) begin
      v = 8'($urandom);
      tx_q.push_back(v);
      wreg(IDX_DATA, v);
    end
    rreg(IDX_LINE_STAT, 8'h00);
    tx_drain();
    rreg(IDX_LINE_STAT, 8'h60);
    finish_test();
  end
endmodule : test_uart_line_status_modem_control
bind line_status_ctrl lsr_mcr_monitor u_lsr_mcr_monitor (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX_LINE(RX_LINE), .TX_SERIAL(TX_SERIAL),
  .SERIAL_OUT(SERIAL_OUT), .SERIAL_IN(SERIAL_IN), .RTS_N(RTS_N), .DTR_N(DTR_N),
  .CTS_N(CTS_N), .DSR_N(DSR_N), .RING_N(RING_N), .CARRIER_N(CARRIER_N),
  .MODEM_STATUS(MODEM_STATUS), .IRQ_REQ(IRQ_REQ), .IRQ(IRQ));
`default_nettype wire
